// file: rtl/tbsc_regs.svh
// register offsets, field positions, reset values and timing counts of the timer control block
`ifndef TBSC_REGS_SVH
`define TBSC_REGS_SVH
// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define TBSC_OFF_CTRL 8'h00
`define TBSC_OFF_SMODE 8'h04
`define TBSC_OFF_PRE 8'h08
`define TBSC_OFF_OUTCFG 8'h0C
`define TBSC_OFF_STATUS 8'h10
`define TBSC_OFF_EVENT 8'h14
`define TBSC_OFF_RELOAD 8'h18
`define TBSC_OFF_ACT 8'h1C
`define TBSC_OFF_COUNT 8'h20
`define TBSC_OFF_LOCK 8'h24
// ----------------------------------------------------------------
// control, slave-mode, status and event fields
// ----------------------------------------------------------------
`define TBSC_CTRL_CNT_EN 0
`define TBSC_CTRL_URS 1
`define TBSC_CTRL_AOE 2
`define TBSC_CTRL_BRK_EN 3
`define TBSC_CTRL_BRK_POL 4
`define TBSC_CTRL_IDLE_OFF_STATE_SELECT 5
`define TBSC_CTRL_MOE 6
`define TBSC_CTRL_BIE 9
`define TBSC_CTRL_CIE 10
`define TBSC_CTRL_CDE 11
`define TBSC_CTRL_EXTERNAL_EDGE_CLOCK_ENABLE 12
`define TBSC_CTRL_EXTERNAL_TRIGGER_POLARITY 13
`define TBSC_CTRL_DBG_HALT 14
`define TBSC_CTRL_COM_TRG 15
`define TBSC_SM_CH1P 6
`define TBSC_SM_CH2P 7
`define TBSC_ST_BRK 0
`define TBSC_ST_TRG 1
`define TBSC_ST_COM 2
`define TBSC_ST_MOE 3
`define TBSC_EV_UPD 0
`define TBSC_EV_COM 1
`define TBSC_EV_BRK 2
// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define TBSC_CTRL_RST 16'h0000
`define TBSC_RELOAD_RST 16'hFFFF
`define TBSC_CLK_NS 100
`define TBSC_DEAD_TIME_NS 200
`define TBSC_DEAD_CYC ((`TBSC_DEAD_TIME_NS + `TBSC_CLK_NS - 1) / `TBSC_CLK_NS)
`endif

// file: rtl/tbsc_pkg.sv
// types shared by the timer control block
`include "tbsc_regs.svh"
package tbsc_pkg;
  typedef enum logic [2:0] {
    TBSC_SM_OFF = 3'b000,
    TBSC_SM_RESET = 3'b100,
    TBSC_SM_GATED = 3'b101,
    TBSC_SM_TRIGGER = 3'b110
  } tbsc_slave_type;
  typedef struct packed {
    logic [2:0] output_mode_setting;
    logic main_output_channel_enable;
    logic complementary_channel_enable;
  } tbsc_chan_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tbsc_bus_type;
  typedef struct packed {
    logic brk;
    logic cmp;
    logic ti1;
    logic ti2;
    logic external_trigger_pin;
  } tbsc_pins_type;
  typedef struct packed {
    logic main_channel_output;
    logic main_oe;
    logic complementary_channel_output;
    logic comp_oe;
  } tbsc_out_type;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [7:0] smode;
    tbsc_chan_type [2:0] pre;
    tbsc_chan_type [2:0] act;
    logic [11:0] outcfg;
    logic [1:0] lock;
    logic lock_done;
    logic [1:0] brk_eff;
    logic [15:0] reload;
    logic [15:0] cnt;
    logic break_flag;
    logic trigger_flag;
    logic commutation_flag;
    tbsc_pins_type s1;
    tbsc_pins_type s2;
    tbsc_pins_type s3;
    tbsc_pins_type pf;
    logic trg_prev;
    logic etr_prev;
    logic moe_s1;
    logic moe_s2;
    logic [7:0] idle_cnt;
    logic sw_brk;
    logic upd;
    logic com_dma;
    logic [31:0] rdata;
  } tbsc_state_type;
endpackage

// file: rtl/tbsc_core.sv
// break protection, slave-mode trigger control and commutation of an advanced timer
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns
module tbsc_core #(
  parameter int CHANNELS = 3,
  parameter logic [7:0] DEAD_CYC = 8'(`TBSC_DEAD_CYC)
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire tbsc_pkg::tbsc_bus_type bus,
  output logic [31:0] rdata,
  input wire tbsc_pkg::tbsc_pins_type pins,
  input wire logic clk_fail,
  input wire logic svm_fail,
  input wire logic hard_fault,
  input wire logic debug_halt,
  input wire logic [3:0] itr,
  input wire logic [2:0] oc_ref,
  output tbsc_pkg::tbsc_out_type [2:0] chan_out,
  output logic update_event,
  output logic timer_irq,
  output logic commutation_dma_req,
  output logic [15:0] count
);
  import tbsc_pkg::*;

  tbsc_state_type s_q;
  tbsc_state_type s_d;
  logic moe_q;
  logic moe_d;
  logic moe_clr_n;
  logic brk_async;
  logic brk_sync;
  logic trg_lvl;
  logic trg_rise;
  logic trg_fall;
  logic etr_lvl;
  logic tick;
  logic com_ev;
  logic idle_rdy;
  logic wr_ctrl;
  tbsc_slave_type sms;
  logic [2:0] main_act;
  logic [2:0] comp_act;

  // ----------------------------------------------------------------
  // break request
  // ----------------------------------------------------------------
  // OR of sources
  assign brk_async = (s_q.brk_eff[0] & (~(pins.brk ^ s_q.brk_eff[1]) | pins.cmp | clk_fail
                     | svm_fail | hard_fault)) | s_q.sw_brk;
  assign brk_sync = s_q.brk_eff[0] & (~(s_q.pf.brk ^ s_q.brk_eff[1]) | s_q.pf.cmp | clk_fail
                    | svm_fail | hard_fault);
  assign moe_clr_n = reset_n & ~brk_async;
  assign wr_ctrl = bus.wr && bus.addr == `TBSC_OFF_CTRL;

  always_comb
  begin
    moe_d = moe_q;
    if (wr_ctrl)
      moe_d = bus.wdata[`TBSC_CTRL_MOE] & ~brk_sync;
    if (s_q.upd && s_q.ctrl[`TBSC_CTRL_AOE] && !brk_sync)
      moe_d = 1'b1;
  end

  // the clear may come with no clock at all, so this flop sits outside the state record
  always_ff @(posedge ref_clk or negedge moe_clr_n)
  begin
    if (!moe_clr_n)
      moe_q <= 1'b0;
    else
      moe_q <= moe_d;
  end

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  assign sms = tbsc_slave_type'(s_q.smode[2:0]);

  always_comb
  begin
    unique case (s_q.smode[5:3])
      3'b100: trg_lvl = s_q.pf.ti1;
      3'b101: trg_lvl = s_q.pf.ti1 ^ s_q.smode[`TBSC_SM_CH1P];
      3'b110: trg_lvl = s_q.pf.ti2 ^ s_q.smode[`TBSC_SM_CH2P];
      3'b111: trg_lvl = s_q.pf.external_trigger_pin ^ s_q.ctrl[`TBSC_CTRL_EXTERNAL_TRIGGER_POLARITY];
      default: trg_lvl = itr[s_q.smode[4:3]];
    endcase
  end

  assign trg_rise = trg_lvl & ~s_q.trg_prev;
  assign trg_fall = ~trg_lvl & s_q.trg_prev;
  assign etr_lvl = s_q.pf.external_trigger_pin ^ s_q.ctrl[`TBSC_CTRL_EXTERNAL_TRIGGER_POLARITY];
  assign tick = s_q.ctrl[`TBSC_CTRL_CNT_EN] & ~(debug_halt & s_q.ctrl[`TBSC_CTRL_DBG_HALT])
                & (~s_q.ctrl[`TBSC_CTRL_EXTERNAL_EDGE_CLOCK_ENABLE] | (etr_lvl & ~s_q.etr_prev))
                & (sms != TBSC_SM_GATED | trg_lvl);
  assign com_ev = (bus.wr && bus.addr == `TBSC_OFF_EVENT && bus.wdata[`TBSC_EV_COM])
                  | (s_q.ctrl[`TBSC_CTRL_COM_TRG] & trg_rise);
  assign idle_rdy = s_q.idle_cnt == DEAD_CYC;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int b = 0; b < 5; b++)
      if (s_q.s2[b] == s_q.s3[b])
        s_d.pf[b] = s_q.s3[b];
    s_d.trg_prev = trg_lvl;
    s_d.etr_prev = etr_lvl;
    // readback path of the output enable
    s_d.moe_s1 = moe_q;
    s_d.moe_s2 = s_q.moe_s1;
    // dead-time restarts only once the resynchronised enable has fallen
    if (s_q.moe_s2)
      s_d.idle_cnt = 8'h00;
    else if (!idle_rdy)
      s_d.idle_cnt = s_q.idle_cnt + 8'h01;
    // configuration lags the write by one cycle
    s_d.brk_eff = {s_q.ctrl[`TBSC_CTRL_BRK_POL], s_q.ctrl[`TBSC_CTRL_BRK_EN]};
    s_d.sw_brk = 1'b0;
    s_d.upd = 1'b0;
    s_d.com_dma = 1'b0;
    s_d.rdata = 32'h0000_0000;
    if (bus.rd)
    begin
      unique case (bus.addr)
        // break bits read back their effective copy, so a write shows one cycle later
        `TBSC_OFF_CTRL: s_d.rdata = {16'h0000, s_q.ctrl[15:7], s_q.moe_s2, s_q.ctrl[5],
                                     s_q.brk_eff, s_q.ctrl[2:0]};
        `TBSC_OFF_SMODE: s_d.rdata = {24'h00_0000, s_q.smode};
        `TBSC_OFF_PRE: s_d.rdata = {17'h0_0000, s_q.pre};
        `TBSC_OFF_OUTCFG: s_d.rdata = {20'h0_0000, s_q.outcfg};
        `TBSC_OFF_STATUS: s_d.rdata = {28'h000_0000, s_q.moe_s2, s_q.commutation_flag,
                                       s_q.trigger_flag, s_q.break_flag};
        `TBSC_OFF_RELOAD: s_d.rdata = {16'h0000, s_q.reload};
        `TBSC_OFF_ACT: s_d.rdata = {17'h0_0000, s_q.act};
        `TBSC_OFF_COUNT: s_d.rdata = {16'h0000, s_q.cnt};
        `TBSC_OFF_LOCK: s_d.rdata = {29'h0000_0000, s_q.lock_done, s_q.lock};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (bus.wr)
    begin
      unique case (bus.addr)
        `TBSC_OFF_CTRL:
        begin
          s_d.ctrl = bus.wdata[15:0];
          s_d.ctrl[`TBSC_CTRL_MOE] = 1'b0;
          if (s_q.lock != 2'b00)
          begin
            s_d.ctrl[`TBSC_CTRL_BRK_EN] = s_q.ctrl[`TBSC_CTRL_BRK_EN];
            s_d.ctrl[`TBSC_CTRL_BRK_POL] = s_q.ctrl[`TBSC_CTRL_BRK_POL];
            s_d.ctrl[`TBSC_CTRL_IDLE_OFF_STATE_SELECT] = s_q.ctrl[`TBSC_CTRL_IDLE_OFF_STATE_SELECT];
          end
        end
        `TBSC_OFF_SMODE: s_d.smode = bus.wdata[7:0];
        `TBSC_OFF_PRE:
          if (s_q.lock != 2'b11)
            s_d.pre = bus.wdata[14:0];
        `TBSC_OFF_OUTCFG:
        begin
          if (s_q.lock == 2'b00)
            s_d.outcfg[5:0] = bus.wdata[5:0];
          if (s_q.lock < 2'b10)
            s_d.outcfg[11:6] = bus.wdata[11:6];
        end
        `TBSC_OFF_STATUS:
        begin
          if (bus.wdata[`TBSC_ST_BRK] && !brk_sync)
            s_d.break_flag = 1'b0;
          if (bus.wdata[`TBSC_ST_TRG])
            s_d.trigger_flag = 1'b0;
          if (bus.wdata[`TBSC_ST_COM])
            s_d.commutation_flag = 1'b0;
        end
        `TBSC_OFF_EVENT:
        begin
          s_d.sw_brk = bus.wdata[`TBSC_EV_BRK];
          if (bus.wdata[`TBSC_EV_UPD])
          begin
            s_d.cnt = 16'h0000;
            s_d.upd = 1'b1;
          end
        end
        `TBSC_OFF_RELOAD: s_d.reload = bus.wdata[15:0];
        `TBSC_OFF_LOCK:
          if (!s_q.lock_done)
          begin
            s_d.lock = bus.wdata[1:0];
            s_d.lock_done = 1'b1;
          end
        default: s_d = s_d;
      endcase
    end
    // hardware events come after software clears so a coincident set is kept
    // break flag
    if (brk_sync || s_q.sw_brk)
      s_d.break_flag = 1'b1;
    if (tick)
    begin
      if (s_q.cnt == s_q.reload)
      begin
        s_d.cnt = 16'h0000;
        s_d.upd = 1'b1;
      end
      else
        s_d.cnt = s_q.cnt + 16'h0001;
    end
    unique case (sms)
      TBSC_SM_RESET:
        if (trg_rise)
        begin
          s_d.cnt = 16'h0000;
          s_d.upd = ~s_q.ctrl[`TBSC_CTRL_URS];
          s_d.trigger_flag = 1'b1;
        end
      TBSC_SM_TRIGGER:
        if (trg_rise)
        begin
          s_d.ctrl[`TBSC_CTRL_CNT_EN] = 1'b1;
          s_d.trigger_flag = 1'b1;
        end
      TBSC_SM_GATED:
        if (trg_rise || trg_fall)
          s_d.trigger_flag = 1'b1;
      default: s_d.trigger_flag = s_d.trigger_flag;
    endcase
    if (com_ev)
    begin
      s_d.act = s_q.pre;
      s_d.commutation_flag = 1'b1;
      s_d.com_dma = s_q.ctrl[`TBSC_CTRL_CDE];
    end
  end

  // break off, flags and enables clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.ctrl <= `TBSC_CTRL_RST;
      s_q.reload <= `TBSC_RELOAD_RST;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // channel outputs
  // ----------------------------------------------------------------
  // outputs stay combinational so a break reaches the pins with no clock
  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    logic refm;
    logic m_idle;
    logic c_idle;
    logic m_pol;
    logic c_pol;
    tbsc_chan_type ac;
    assign ac = s_q.act[i];
    assign m_pol = s_q.outcfg[6 + i];
    assign c_pol = s_q.outcfg[9 + i];
    always_comb
    begin
      unique case (ac.output_mode_setting)
        3'b100: refm = 1'b0;
        3'b101: refm = 1'b1;
        3'b111: refm = ~oc_ref[i];
        default: refm = oc_ref[i];
      endcase
    end
    assign m_idle = s_q.outcfg[i] ^ m_pol;
    assign c_idle = s_q.outcfg[3 + i] ^ c_pol;
    // complementary side yields when both would be active
    always_comb
    begin
      if (moe_q)
      begin
        main_act[i] = refm & ac.main_output_channel_enable;
        comp_act[i] = (ac.main_output_channel_enable ? ~refm : refm)
                      & ac.complementary_channel_enable;
      end
      else if (!idle_rdy)
      begin
        main_act[i] = 1'b0;
        comp_act[i] = 1'b0;
      end
      else
      begin
        main_act[i] = m_idle;
        comp_act[i] = c_idle & ~m_idle;
      end
      if (main_act[i])
        comp_act[i] = 1'b0;
    end
    assign chan_out[i].main_channel_output = main_act[i] ^ m_pol;
    assign chan_out[i].complementary_channel_output = comp_act[i] ^ c_pol;
    // with the main enable low, enables released unless idle off-state is set
    assign chan_out[i].main_oe = moe_q ? ac.main_output_channel_enable
      : s_q.ctrl[`TBSC_CTRL_IDLE_OFF_STATE_SELECT] & (ac.main_output_channel_enable
      | ac.complementary_channel_enable);
    assign chan_out[i].comp_oe = moe_q ? ac.complementary_channel_enable
      : s_q.ctrl[`TBSC_CTRL_IDLE_OFF_STATE_SELECT] & (ac.main_output_channel_enable
      | ac.complementary_channel_enable);
  end

  assign rdata = s_q.rdata;
  assign update_event = s_q.upd;
  assign count = s_q.cnt;
  assign commutation_dma_req = s_q.com_dma;
  assign timer_irq = (s_q.break_flag & s_q.ctrl[`TBSC_CTRL_BIE])
                     | (s_q.commutation_flag & s_q.ctrl[`TBSC_CTRL_CIE]);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence break_fall_s;
    $fell(moe_q);
  endsequence
  sequence reset_hold_s;
    (!idle_rdy)[*3];
  endsequence

  never_both_a: assert property (((main_act & comp_act) == 3'b000))
    else $error("main and complementary both active");
  cfg_lag_a: assert property (wr_ctrl && s_q.lock == 2'b00 |-> ##2
    s_q.brk_eff[0] == $past(bus.wdata[`TBSC_CTRL_BRK_EN], 2))
    else $error("break enable did not take effect one cycle after write");
  break_clear_a: assert property (brk_sync |-> !moe_q)
    else $error("main output enable high during break");
  reset_state_a: assert property (break_fall_s |-> reset_hold_s)
    else $error("idle levels driven before dead-time");
  break_irq_a: assert property (brk_sync |=> s_q.break_flag
    && (!s_q.ctrl[`TBSC_CTRL_BIE] || timer_irq))
    else $error("break flag or interrupt missing");
  auto_enable_a: assert property (s_q.upd && s_q.ctrl[`TBSC_CTRL_AOE] && !brk_sync
    && !brk_async |=> moe_q)
    else $error("automatic output enable did not re-arm");
  flag_hold_a: assert property (brk_sync && s_q.break_flag |=> s_q.break_flag)
    else $error("break flag cleared while break active");
  lock_once_a: assert property (s_q.lock_done |=> $stable(s_q.lock))
    else $error("lock field written twice");
  reset_mode_a: assert property (sms == TBSC_SM_RESET && trg_rise |=>
    s_q.cnt == 16'h0000 && s_q.trigger_flag)
    else $error("reset slave mode did not clear counter");
  trigger_start_a: assert property (sms == TBSC_SM_TRIGGER && trg_rise |=>
    s_q.ctrl[`TBSC_CTRL_CNT_EN] && s_q.trigger_flag)
    else $error("trigger slave mode did not start counter");
  com_copy_a: assert property (com_ev |=> s_q.act == $past(s_q.pre)
    && s_q.commutation_flag)
    else $error("commutation did not copy preloads");
endmodule

// file: tb/tbsc_far_end.sv
// far side model: break and trigger pins, comparator and the power stage
`timescale 1ns/1ns
module tbsc_far_end (
  input wire logic ref_clk,
  input wire logic [4:0] lvl,
  input wire tbsc_pkg::tbsc_out_type [2:0] chan_out,
  output tbsc_pkg::tbsc_pins_type pins,
  output logic [7:0] shoot
);
  import tbsc_pkg::*;
  initial
  begin
    pins = '0;
    shoot = 8'h00;
  end
  // pin levels move just after the clock edge, like a board signal would
  always @(posedge ref_clk)
    pins <= tbsc_pins_type'(lvl);
  // ----------------------------------------------------------------
  // power stage
  // ----------------------------------------------------------------
  // leg shorted
  // assumes active-high polarity, which the bench never changes
  always @(negedge ref_clk)
    for (int i = 0; i < 3; i++)
      if (chan_out[i].main_channel_output && chan_out[i].main_oe &&
          chan_out[i].complementary_channel_output && chan_out[i].comp_oe)
        shoot <= shoot + 8'h01;
endmodule

// file: tb/tb_top.sv
// self-checking bench of the timer break, slave-mode and commutation block
`timescale 1ns/1ns
`include "tbsc_regs.svh"
module tb_top;
  import tbsc_pkg::*;
  localparam logic [7:0] A_CT = `TBSC_OFF_CTRL;
  localparam logic [7:0] A_SM = `TBSC_OFF_SMODE;
  localparam logic [7:0] A_PR = `TBSC_OFF_PRE;
  localparam logic [7:0] A_OC = `TBSC_OFF_OUTCFG;
  localparam logic [7:0] A_ST = `TBSC_OFF_STATUS;
  localparam logic [7:0] A_EV = `TBSC_OFF_EVENT;
  localparam logic [7:0] A_AC = `TBSC_OFF_ACT;
  localparam logic [7:0] A_LK = `TBSC_OFF_LOCK;
  logic ref_clk;
  logic reset_n;
  tbsc_bus_type bus;
  logic [31:0] rdata;
  tbsc_pins_type pins;
  logic [4:0] lvl;
  logic [3:0] src;
  logic dbg;
  logic [3:0] itr;
  tbsc_out_type [2:0] chan_out;
  logic timer_irq;
  logic dma;
  logic upd;
  logic [15:0] count;
  logic [7:0] shoot;
  int fails = 0;
  int checks = 0;
  int dma_cnt = 0;
  int upd_cnt = 0;
  logic [15:0] c;
  tbsc_core uut (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .pins(pins), .clk_fail(src[0]), .svm_fail(src[1]), .hard_fault(src[2]),
    .debug_halt(dbg), .itr(itr), .oc_ref(3'h0), .chan_out(chan_out), .update_event(upd),
    .timer_irq(timer_irq), .commutation_dma_req(dma), .count(count));
  // comparator output rides on its own pin bit
  tbsc_far_end far (.ref_clk(ref_clk), .lvl({lvl[4], src[3], lvl[2:0]}),
    .chan_out(chan_out), .pins(pins), .shoot(shoot));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (dma === 1'b1)
      dma_cnt++;
    if (upd === 1'b1)
      upd_cnt++;
  end
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    // look at outputs mid-cycle, away from the edge that launches them
    @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic pin(input int b, input logic v);
    @(posedge ref_clk);
    lvl[b] <= v;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
    chk(d & m, exp);
  endtask
  task automatic end_of_test();
    $display("fails=%0d checks=%0d", fails, checks);
    if (fails == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(A_CT, 32'hFFFF, 32'h0); // control clear
    rchk(A_ST, 32'hF, 32'h0); // main enable low
    rchk(`TBSC_OFF_RELOAD, 32'hFFFF, 32'hFFFF); // reload after reset
    rchk(8'h3C, 32'hFFFFFFFF, 32'h0); // unmapped reads zero
    wr(A_CT, 32'h18);
    cyc(1);
    rchk(A_CT, 32'h18, 32'h18); // read after wait
  endtask
  task automatic t_commute();
    int n;
    wr(A_CT, 32'h8C00);
    wr(A_SM, 32'h0);
    wr(A_PR, 32'h0B);
    rchk(A_AC, 32'h1F, 32'h0); // preload held
    @(posedge ref_clk);
    itr[0] <= 1'b1;
    cyc(4);
    rchk(A_AC, 32'h1F, 32'h0B); // trigger rise
    rchk(A_ST, 32'h4, 32'h4); // flag set
    chk(32'(timer_irq), 1); // interrupt
    wr(A_ST, 32'h7);
    wr(A_CT, 32'h0C00);
    wr(A_PR, 32'h17);
    n = dma_cnt;
    wr(A_EV, 32'h2);
    cyc(3);
    chk(32'(dma_cnt - n), 1); // one request
    rchk(A_AC, 32'h1F, 32'h17); // copied at once
  endtask
  task automatic t_break();
    wr(A_ST, 32'h7);
    wr(A_OC, 32'h1);
    wr(A_CT, 32'h0258);
    rchk(A_ST, 32'h8, 32'h0); // read lags the write
    cyc(4);
    rchk(A_ST, 32'h8, 32'h8); // enable reads back
    chk(32'(chan_out[0].main_oe), 1);
    pin(4, 1'b1);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(32'(chan_out[0].main_oe), 0); // cleared at once
    chk(32'(chan_out[0].main_channel_output), 0); // reset state
    cyc(10);
    chk(32'(chan_out[0].main_channel_output), 1); // idle level
    rchk(A_ST, 32'h9, 32'h1); // flag set
    chk(32'(timer_irq), 1); // interrupt
    wr(A_CT, 32'h0258);
    wr(A_ST, 32'h1);
    cyc(3);
    rchk(A_ST, 32'h9, 32'h1); // no re-enable
    pin(4, 1'b0);
    cyc(8);
    wr(A_ST, 32'h1);
    rchk(A_ST, 32'h9, 32'h0); // stays low
  endtask
  task automatic t_sources();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge ref_clk);
      src[i] <= 1'b1;
      cyc(5);
      src[i] <= 1'b0;
      cyc(8);
      rchk(A_ST, 32'h1, 32'h1); // each source
      wr(A_ST, 32'h1);
    end
    wr(A_CT, 32'h023C);
    wr(A_EV, 32'h4);
    cyc(4);
    rchk(A_ST, 32'h9, 32'h1); // software break
    chk(32'(chan_out[0].main_oe), 1); // enable kept by idle off-state
    wr(A_EV, 32'h1);
    cyc(4);
    rchk(A_ST, 32'h8, 32'h8); // set on update
  endtask
  task automatic t_lock();
    wr(A_LK, 32'h1);
    wr(A_LK, 32'h3);
    rchk(A_LK, 32'h7, 32'h5); // one write only
    wr(A_CT, 32'h0);
    cyc(2);
    rchk(A_CT, 32'h18, 32'h18); // break bits frozen
  endtask
  task automatic t_slave();
    int n;
    wr(A_SM, 32'h2C);
    wr(A_CT, 32'h1);
    cyc(20);
    n = upd_cnt;
    pin(2, 1'b1);
    cyc(1);
    chk(32'(count > 16'h000A), 1); // resync lag
    cyc(6);
    chk(32'(count < 16'h0008), 1); // counter cleared
    chk(32'(upd_cnt - n), 1); // update event
    rchk(A_ST, 32'h2, 32'h2); // flag set
    wr(A_CT, 32'h3);
    pin(2, 1'b0);
    cyc(20);
    n = upd_cnt;
    pin(2, 1'b1);
    cyc(7);
    chk(32'(count < 16'h0008), 1); // cleared again
    chk(32'(upd_cnt - n), 0); // no update with source bit
    wr(A_CT, 32'h0);
    wr(A_SM, 32'h36);
    wr(A_ST, 32'h7);
    c = count;
    cyc(5);
    chk(32'(count), 32'(c)); // waits for edge
    pin(1, 1'b1);
    cyc(8);
    chk(32'(count > c), 1); // started
    rchk(A_ST, 32'h2, 32'h2); // input two
  endtask
  task automatic t_gated();
    wr(A_SM, 32'h6D);
    wr(A_CT, 32'h1);
    wr(A_ST, 32'h7);
    c = count;
    cyc(4);
    chk(32'(count), 32'(c)); // inverted input
    pin(2, 1'b0);
    cyc(8);
    chk(32'(count > c), 1); // counts while low
    rchk(A_ST, 32'h2, 32'h2); // flag on start
    wr(A_CT, 32'h4001);
    dbg <= 1'b1;
    cyc(2);
    c = count;
    cyc(4);
    chk(32'(count), 32'(c)); // halted
    dbg <= 1'b0;
    wr(A_ST, 32'h2);
    pin(2, 1'b1);
    cyc(8);
    c = count;
    cyc(4);
    chk(32'(count), 32'(c)); // stops
    rchk(A_ST, 32'h2, 32'h2); // flag on stop
  endtask
  task automatic t_extclk();
    wr(A_CT, 32'h1000);
    pin(2, 1'b0);
    cyc(8);
    wr(A_SM, 32'h2E);
    wr(A_ST, 32'h7);
    cyc(1);
    c = count;
    pin(2, 1'b1);
    cyc(8);
    chk(32'(count), 32'(c)); // waits for pin edges
    rchk(A_CT, 32'h1, 32'h1); // started by trigger
    repeat (3)
    begin
      pin(0, 1'b1);
      cyc(6);
      pin(0, 1'b0);
      cyc(6);
    end
    chk(32'(count), 32'(c + 16'h0003)); // one count per rising edge
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    bus = '0;
    lvl = 5'h00;
    src = 4'h0;
    dbg = 1'b0;
    itr = 4'h0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_commute();
    t_break();
    t_sources();
    t_lock();
    t_slave();
    t_gated();
    t_extclk();
    chk(32'(shoot), 0); // no shoot-through
    end_of_test();
  end
  // the sequence needs well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    end_of_test();
  end
endmodule
